// >>> logic/dq_training_fifo_consts.vh
`ifndef DQ_TRAINING_FIFO_CONSTS_VH
`define DQ_TRAINING_FIFO_CONSTS_VH

// ==========================================================
// fifo geometry
`define FIFO_DEPTH 3'd5
`define FIFO_LAST 3'd4
`define BURST_LEN 5'd16
`define BURST_LAST 4'hf
`define DQ_WIDTH 16
`define DMI_WIDTH 2
`define WORD_WIDTH 18
`define MEM_WORDS 80
`define LAT_STAGES 32
`define UNDEF_FILL 18'h0

// ==========================================================
// command codes from the core command decoder
`define CMD_MPC 4'h1
`define CMD_CAS2 4'h2
`define CMD_WRITE 4'h3
`define CMD_MASKED_WRITE 4'h4
`define CMD_READ 4'h5
`define CMD_READ_AUTO_PRE 4'h6
`define CMD_MODE_REG_READ 4'h7
`define CMD_MODE_REG_WRITE 4'h8

// training function selectors in operand bits 5..0
`define MPC_ENABLE_BIT 6
`define MPC_FN_WR_FIFO 6'h01
`define MPC_FN_RD_FIFO 6'h02
`define MPC_FN_RD_CAL 6'h03

// pending function after an mpc
`define PEND_NONE 2'd0
`define PEND_WR 2'd1
`define PEND_RD 2'd2
`define PEND_CAL 2'd3

// ==========================================================
// register map (byte addresses)
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define CTRL_RESET 32'h0000_0000
`define CTRL_WL_LSB 0
`define CTRL_RL_LSB 8
`define CTRL_WR_INV_BIT 16
`define CTRL_RD_INV_BIT 17
`define CTRL_MASK_EN_BIT 18
`define STAT_WR_PTR_LSB 0
`define STAT_RD_PTR_LSB 4
`define STAT_VALID_LSB 8
`define STAT_WR_BUSY_BIT 16
`define STAT_RD_BUSY_BIT 17
`define STAT_CKE_BIT 18

// ahb-lite encodings
`define HTRANS_NONSEQ 2'b10
`define HRESP_OKAY 1'b0

`endif

// >>> logic/cmd_latency_line.v
`timescale 1ns/10ps
`include "dq_training_fifo_consts.vh"

// ==========================================================
// shift line carrying a start flag and an entry tag; the tap
// picked by latency fires latency plus one cycles after launch
module cmd_latency_line (
    input wire core_clk,
    input wire rst_n,
    input wire launch,
    input wire [2:0] launch_tag,
    input wire [4:0] latency,
    output wire fire,
    output wire [2:0] fire_tag
);
    reg [`LAT_STAGES-1:0] vld_r;
    reg [2:0] tag_r [0:`LAT_STAGES-1];

    // stage zero takes the launch
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            vld_r[0] <= 1'b0;
            tag_r[0] <= 3'h0;
        end else begin
            vld_r[0] <= launch;
            tag_r[0] <= launch_tag;
        end
    end

    // one stage per cycle of latency
    genvar i;
    generate
        for (i = 1; i < `LAT_STAGES; i = i + 1) begin : g_stage
            always @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    vld_r[i] <= 1'b0;
                    tag_r[i] <= 3'h0;
                end else begin
                    vld_r[i] <= vld_r[i-1];
                    tag_r[i] <= tag_r[i-1];
                end
            end
        end
    endgenerate

    // latency changed mid-flight may drop or repeat a start
    assign fire = vld_r[latency];
    assign fire_tag = tag_r[latency];
endmodule // cmd_latency_line

// >>> logic/dq_training_fifo.v
// Functional notes
// R1: multi-purpose command with operand bit 6 low is a no-op.
// R2: with bit 6 high, operand bits 5..0 select the training function.
// R3: controller sends CAS-2 right after a fifo-starting multi-purpose cmd.
// R4: controller drives all CAS-2 operand bits low after such a command.
// R5: fifo write data captured like a write, latency from CAS-2 2nd edge.
// R6: fifo read data returned like a read, latency from CAS-2 2nd edge.
// R7: five bursts of sixteen beats stored, eighty values per pin.
// R8: read pointer steps through five entries and wraps to the first.
// R9: reads keep contents; write, read, mode read, cal, cke low disturb.
// R10: unwritten entries read back as defined filler data.
// R11: only set-point and current-boost mode writes between fifo write/read.
// R12: write pointer resets on reset, power-down and self-refresh pd entry.
// R13: fifo write advances write pointer, fifo read advances read pointer.
// R14: ordinary read or read with precharge advances both pointers.
// R15: controller issues no ordinary reads during write training.
// R16: reads equal writes plus a multiple of five at training end.
// R17: fifo writes accepted with banks open, in refresh or self refresh.
// R18: back-to-back fifo reads give a gapless data stream.
// R19: mask/inversion pins driven when inversion or masking is enabled.
// R20: controller waits extra delay after power-down exit before fifo write.
// R21: fifo writes use normal write termination latencies.
// R22: both pointers are modulo-five counters wrapping four to zero.
//
// The register addresses and register access over AHB-Lite were decided locally.
`timescale 1ns/10ps
`include "dq_training_fifo_consts.vh"

module dq_training_fifo (
    input wire core_clk,
    input wire rst_n,
    // ahb-lite slave
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hready,
    input wire [31:0] hwdata,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // decoded commands, same clock
    input wire cmd_valid,
    input wire [3:0] cmd_code,
    input wire [6:0] cmd_op,
    input wire pd_entry,
    input wire sref_pd_entry,
    input wire cke_pin,
    // data path
    input wire [`DQ_WIDTH-1:0] dq_in,
    input wire [`DMI_WIDTH-1:0] mask_inversion_pin_in,
    output reg [`DQ_WIDTH-1:0] dq_out,
    output reg dq_oe_n,
    output reg [`DMI_WIDTH-1:0] mask_inversion_pin_out,
    output reg mask_inversion_pin_oe_n,
    output reg fifo_odt_start
);
    // ======================================================
    // modulo-five pointer step
    function [2:0] ptr_step;
        input [2:0] p;
        begin
            ptr_step = (p == `FIFO_LAST) ? 3'd0 : p + 3'd1; // R22
        end
    endfunction

    // ======================================================
    // registers and state
    reg [31:0] ctrl_r;
    reg [2:0] wr_ptr_r;
    reg [2:0] rd_ptr_r;
    reg [4:0] valid_r;
    reg [1:0] pend_r;
    reg wr_go_r;
    reg rd_go_r;
    reg [2:0] go_tag_r;
    reg cke_s1_r;
    reg cke_s2_r;
    reg cke_s3_r;
    reg cke_r;
    reg wr_act_r;
    reg [3:0] wr_beat_r;
    reg [2:0] wr_ent_r;
    reg rd_act_r;
    reg [3:0] rd_beat_r;
    reg [2:0] rd_ent_r;
    reg [`WORD_WIDTH-1:0] mem [0:`MEM_WORDS-1];
    reg dp_sel_r;
    reg dp_write_r;
    reg [7:0] dp_addr_r;

    wire [4:0] wl = ctrl_r[`CTRL_WL_LSB+4:`CTRL_WL_LSB];
    wire [4:0] rl = ctrl_r[`CTRL_RL_LSB+4:`CTRL_RL_LSB];
    wire lane_drive = ctrl_r[`CTRL_WR_INV_BIT] | ctrl_r[`CTRL_RD_INV_BIT]
        | ctrl_r[`CTRL_MASK_EN_BIT];
    wire wr_fire;
    wire [2:0] wr_fire_tag;
    wire rd_fire;
    wire [2:0] rd_fire_tag;

    // ======================================================
    // command decode
    wire is_mpc = cmd_valid && (cmd_code == `CMD_MPC);
    wire mpc_on = is_mpc && cmd_op[`MPC_ENABLE_BIT]; // R1
    wire is_cas2 = cmd_valid && (cmd_code == `CMD_CAS2);
    wire do_wr_fifo = is_cas2 && (pend_r == `PEND_WR);
    wire do_rd_fifo = is_cas2 && (pend_r == `PEND_RD);
    wire do_cal = is_cas2 && (pend_r == `PEND_CAL);
    wire is_rd = cmd_valid && ((cmd_code == `CMD_READ)
        || (cmd_code == `CMD_READ_AUTO_PRE));
    wire is_wr = cmd_valid && ((cmd_code == `CMD_WRITE)
        || (cmd_code == `CMD_MASKED_WRITE));
    wire is_mrr = cmd_valid && (cmd_code == `CMD_MODE_REG_READ);
    wire cke_fall = cke_r && !cke_s3_r && (cke_s2_r == cke_s3_r);
    wire disturb = is_rd | is_wr | is_mrr | do_cal | cke_fall; // R9

    // ======================================================
    // cke pin synchroniser, change taken when stages 2 and 3 agree
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cke_s1_r <= 1'b0;
            cke_s2_r <= 1'b0;
            cke_s3_r <= 1'b0;
            cke_r <= 1'b0;
        end else begin
            cke_s1_r <= cke_pin;
            cke_s2_r <= cke_s1_r;
            cke_s3_r <= cke_s2_r;
            if (cke_s2_r == cke_s3_r) begin
                cke_r <= cke_s3_r;
            end
        end
    end

    // ======================================================
    // pending training function; only the very next command may
    // be its CAS-2, anything else drops it
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_r <= `PEND_NONE;
        end else if (cmd_valid) begin
            pend_r <= `PEND_NONE;
            if (mpc_on) begin
                case (cmd_op[5:0]) // R2
                    `MPC_FN_WR_FIFO: pend_r <= `PEND_WR;
                    `MPC_FN_RD_FIFO: pend_r <= `PEND_RD;
                    `MPC_FN_RD_CAL: pend_r <= `PEND_CAL;
                    default: pend_r <= `PEND_NONE; // reserved codes
                endcase
            end
        end
    end

    // ======================================================
    // launch pulses on the edge after CAS-2, i.e. its 2nd edge
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_go_r <= 1'b0;
            rd_go_r <= 1'b0;
            go_tag_r <= 3'd0;
            fifo_odt_start <= 1'b0;
        end else begin
            wr_go_r <= do_wr_fifo; // R17
            rd_go_r <= do_rd_fifo;
            go_tag_r <= do_wr_fifo ? wr_ptr_r : rd_ptr_r;
            fifo_odt_start <= do_wr_fifo; // R21
        end
    end

    // ======================================================
    // pointers: power-down entries reset only the write side
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= 3'd0; // R12
            rd_ptr_r <= 3'd0;
        end else begin
            if (pd_entry || sref_pd_entry) begin
                wr_ptr_r <= 3'd0; // R12
            end else if (do_wr_fifo || is_rd) begin
                wr_ptr_r <= ptr_step(wr_ptr_r); // R13 R14
            end
            if (do_rd_fifo || is_rd) begin
                rd_ptr_r <= ptr_step(rd_ptr_r); // R8 R13 R14
            end
        end
    end

    // ======================================================
    // valid mask; a fifo write in the same cycle beats a disturb
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            valid_r <= 5'h00;
        end else begin
            if (disturb) begin
                valid_r <= 5'h00; // R9
            end
            if (wr_go_r) begin
                valid_r[go_tag_r] <= 1'b1;
            end
        end
    end

    // ======================================================
    // latency lines for both directions
    cmd_latency_line u_wr_lat (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .launch(wr_go_r),
        .launch_tag(go_tag_r),
        .latency(wl),
        .fire(wr_fire),
        .fire_tag(wr_fire_tag)
    );

    cmd_latency_line u_rd_lat (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .launch(rd_go_r),
        .launch_tag(go_tag_r),
        .latency(rl),
        .fire(rd_fire),
        .fire_tag(rd_fire_tag)
    );

    // ======================================================
    // write burst: sixteen beats into the selected entry
    wire [3:0] wr_beat = wr_fire ? 4'h0 : wr_beat_r;
    wire [2:0] wr_ent = wr_fire ? wr_fire_tag : wr_ent_r;
    wire [6:0] wr_idx = {wr_ent, 4'h0} + {3'h0, wr_beat}; // R7

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_act_r <= 1'b0;
            wr_beat_r <= 4'h0;
            wr_ent_r <= 3'd0;
        end else if (wr_fire) begin
            wr_act_r <= 1'b1; // R5
            wr_beat_r <= 4'h1;
            wr_ent_r <= wr_fire_tag;
        end else if (wr_act_r) begin
            wr_beat_r <= wr_beat_r + 4'h1;
            if (wr_beat_r == `BURST_LAST) begin
                wr_act_r <= 1'b0;
            end
        end
    end

    // storage has no reset; unwritten words are masked by valid_r
    always @(posedge core_clk) begin
        if (wr_fire || wr_act_r) begin
            mem[wr_idx] <= {mask_inversion_pin_in, dq_in}; // R5
        end
    end

    // ======================================================
    // read burst; a new start right after beat 15 keeps it gapless
    wire [3:0] rd_beat = rd_fire ? 4'h0 : rd_beat_r;
    wire [2:0] rd_ent = rd_fire ? rd_fire_tag : rd_ent_r;
    wire [6:0] rd_idx = {rd_ent, 4'h0} + {3'h0, rd_beat};
    wire [`WORD_WIDTH-1:0] rd_word = valid_r[rd_ent] ? mem[rd_idx]
        : `UNDEF_FILL; // R9 R10

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_act_r <= 1'b0;
            rd_beat_r <= 4'h0;
            rd_ent_r <= 3'd0;
            dq_out <= 16'h0000;
            dq_oe_n <= 1'b1;
            mask_inversion_pin_out <= 2'h0;
            mask_inversion_pin_oe_n <= 1'b1;
        end else if (rd_fire || rd_act_r) begin
            rd_act_r <= 1'b1; // R6 R18
            rd_beat_r <= rd_beat + 4'h1;
            rd_ent_r <= rd_ent;
            if (!rd_fire && rd_beat_r == `BURST_LAST) begin
                rd_act_r <= 1'b0;
            end
            dq_out <= rd_word[`DQ_WIDTH-1:0];
            dq_oe_n <= 1'b0;
            mask_inversion_pin_out <= rd_word[`WORD_WIDTH-1:`DQ_WIDTH];
            mask_inversion_pin_oe_n <= !lane_drive; // R19
        end else begin
            dq_oe_n <= 1'b1;
            mask_inversion_pin_oe_n <= 1'b1;
        end
    end

    // ======================================================
    // ahb-lite slave, zero wait states, always okay
    wire ahb_take = hsel && hready && (htrans == `HTRANS_NONSEQ);

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dp_sel_r <= 1'b0;
            dp_write_r <= 1'b0;
            dp_addr_r <= 8'h00;
        end else if (hready) begin
            dp_sel_r <= ahb_take;
            dp_write_r <= hwrite;
            dp_addr_r <= haddr;
        end
    end

    // ctrl write lands at the end of the data phase
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= `CTRL_RESET;
        end else if (dp_sel_r && dp_write_r
                && dp_addr_r == `REG_CTRL) begin
            ctrl_r <= hwdata & 32'h0007_1f1f;
        end
    end

    // read data registered from the address phase
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= `HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp <= `HRESP_OKAY;
            if (ahb_take && !hwrite) begin
                case (haddr)
                    `REG_CTRL: hrdata <= ctrl_r;
                    `REG_STATUS: hrdata <= {13'h0000, cke_r, rd_act_r,
                        wr_act_r, 3'h0, valid_r, 1'b0, rd_ptr_r,
                        1'b0, wr_ptr_r};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // dq_training_fifo

// >>> verif/dq_training_fifo_sva.sv
`timescale 1ns/10ps
`include "dq_training_fifo_consts.vh"

// ==========================================================
// port checker for the training fifo
module dq_training_fifo_sva (
    input wire core_clk,
    input wire rst_n,
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hwdata,
    input wire hreadyout,
    input wire hresp,
    input wire cmd_valid,
    input wire [3:0] cmd_code,
    input wire [6:0] cmd_op,
    input wire dq_oe_n,
    input wire mask_inversion_pin_oe_n,
    input wire fifo_odt_start
);
    reg ctl_wr_r;
    reg [31:0] ctl_r;
    reg rd_mpc_r;
    reg [5:0] lead_r;
    reg [7:0] low_r;
    wire mpc = cmd_valid && cmd_code == `CMD_MPC;
    wire cas = cmd_valid && cmd_code == `CMD_CAS2;

    // shadow of control, so latency and lane enables are known here
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_wr_r <= 1'b0;
            ctl_r <= `CTRL_RESET;
        end else if (hready) begin
            if (ctl_wr_r)
                ctl_r <= hwdata;
            ctl_wr_r <= hsel && htrans == `HTRANS_NONSEQ && hwrite &&
                haddr == `REG_CTRL;
        end
    end

    // lead counts down to the first read beat; low counts drive cycles
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_mpc_r <= 1'b0;
            lead_r <= 6'h00;
            low_r <= 8'h00;
        end else begin
            rd_mpc_r <= mpc && cmd_op == {1'b1, `MPC_FN_RD_FIFO};
            if (cas && rd_mpc_r)
                lead_r <= {1'b0, ctl_r[12:8]} + 6'h03;
            else if (lead_r != 6'h00)
                lead_r <= lead_r - 6'h01;
            low_r <= dq_oe_n ? 8'h00 : low_r + 8'h01;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    odt_start_a: assert property (
        mpc && cmd_op == {1'b1, `MPC_FN_WR_FIFO} ##1 cas |=> fifo_odt_start)
        else $error("no termination pulse after fifo write");
    odt_cause_a: assert property (
        fifo_odt_start |-> $past(cas) && $past(mpc, 2) && !$past(fifo_odt_start))
        else $error("termination pulse without fifo write");
    noop_quiet_a: assert property (
        mpc && !cmd_op[6] ##1 cas |=> !fifo_odt_start)
        else $error("disabled command acted");
    reserved_quiet_a: assert property (
        mpc && cmd_op[6] && cmd_op[5:0] > `MPC_FN_RD_CAL ##1 cas
        |=> !fifo_odt_start)
        else $error("reserved selector acted");
    read_start_a: assert property (
        lead_r == 6'h01 |-> !dq_oe_n)
        else $error("read burst late");
    read_early_a: assert property (
        lead_r == 6'h02 && low_r == 8'h00 |-> dq_oe_n)
        else $error("read burst early");
    burst_len_a: assert property (
        $rose(dq_oe_n) |-> low_r[3:0] == 4'h0 && low_r != 8'h00)
        else $error("drive window not whole bursts");
    mask_drive_a: assert property (
        !dq_oe_n && ctl_r[18:16] != 3'h0 |-> !mask_inversion_pin_oe_n)
        else $error("mask lanes not driven");
    mask_quiet_a: assert property (
        !mask_inversion_pin_oe_n |-> !dq_oe_n && ctl_r[18:16] != 3'h0)
        else $error("mask lanes driven when off");
    bus_okay_a: assert property (hreadyout && hresp == `HRESP_OKAY)
        else $error("bus not ready or not okay");
endmodule // dq_training_fifo_sva

bind dq_training_fifo dq_training_fifo_sva sva (
    .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_op(cmd_op), .dq_oe_n(dq_oe_n),
    .mask_inversion_pin_oe_n(mask_inversion_pin_oe_n),
    .fifo_odt_start(fifo_odt_start)
);

// >>> verif/mem_ctl_model.sv
`timescale 1ns/10ps
`include "dq_training_fifo_consts.vh"

// ==========================================================
// controller side: command bus and write data lanes
module mem_ctl_model (
    input wire core_clk,
    output reg cmd_valid,
    output reg [3:0] cmd_code,
    output reg [6:0] cmd_op,
    output reg [15:0] dq_in,
    output reg [1:0] mask_inversion_pin_in
);
    // beat pattern, distinct for every seed and beat
    function automatic [17:0] pat(input [7:0] s, input [3:0] k);
        pat = {k[1:0] ^ s[1:0], s, ~s[3:0], k};
    endfunction

    // idle bus at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 4'hf;
        cmd_op = 7'h00;
        {mask_inversion_pin_in, dq_in} = 18'h0;
    end

    task send(input [3:0] c, input [6:0] o);
        cmd_valid <= 1'b1;
        cmd_code <= c;
        cmd_op <= o;
        @(posedge core_clk);
    endtask

    // released lines flip so a stale value never looks valid
    task idle;
        cmd_valid <= 1'b0;
        cmd_code <= ~cmd_code;
        cmd_op <= ~cmd_op;
    endtask

    task cmd(input [3:0] c);
        send(c, 7'h00);
        idle;
    endtask

    // column command follows at once with operands low
    task mpc(input [6:0] o);
        send(`CMD_MPC, o);
        send(`CMD_CAS2, 7'h00);
        idle;
    endtask

    task wr_burst(input [7:0] s, input [4:0] wl);
        integer k;
        mpc({1'b1, `MPC_FN_WR_FIFO});
        repeat (wl + 1) @(posedge core_clk);
        for (k = 0; k < 16; k++) begin
            {mask_inversion_pin_in, dq_in} <= pat(s, k[3:0]);
            @(posedge core_clk);
        end
        {mask_inversion_pin_in, dq_in} <= ~{mask_inversion_pin_in, dq_in};
    endtask
endmodule // mem_ctl_model

// >>> verif/dq_training_fifo_bench.sv
`timescale 1ns/10ps
`include "dq_training_fifo_consts.vh"

module dq_training_fifo_bench;
    localparam [4:0] WL = 5'd2;
    localparam [4:0] RL = 5'd3;
    reg core_clk = 1'b0;
    reg rst_n = 1'b0;
    reg hsel = 1'b0;
    reg [7:0] haddr = 8'h00;
    reg [1:0] htrans = 2'b00;
    reg hwrite = 1'b0;
    reg [2:0] hsize = 3'h2;
    reg [31:0] hwdata = 32'h0;
    reg pd_entry = 1'b0;
    reg sref_pd_entry = 1'b0;
    reg cke_pin = 1'b1;
    wire [31:0] hrdata;
    wire hreadyout, hresp, cmd_valid, dq_oe_n, mi_oe_n, fifo_odt_start;
    wire [3:0] cmd_code;
    wire [6:0] cmd_op;
    wire [15:0] dq_in, dq_out;
    wire [1:0] mi_in, mi_out;
    integer n_mismatch = 0;
    integer tests_run = 0;
    integer cyc = 0;
    integer i, j;
    reg [17:0] exp_mem [0:4][0:15];
    reg [4:0] vld = 5'h0;
    reg [2:0] wp = 3'h0;
    reg [2:0] rp = 3'h0;
    reg [2:0] lane_en = 3'h0;
    reg [31:0] rd;

    dq_training_fifo dut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_op(cmd_op), .pd_entry(pd_entry),
        .sref_pd_entry(sref_pd_entry), .cke_pin(cke_pin), .dq_in(dq_in),
        .mask_inversion_pin_in(mi_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .mask_inversion_pin_out(mi_out), .mask_inversion_pin_oe_n(mi_oe_n),
        .fifo_odt_start(fifo_odt_start));
    mem_ctl_model ctl (.core_clk(core_clk), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_op(cmd_op), .dq_in(dq_in),
        .mask_inversion_pin_in(mi_in));

    // ==========================================================
    // clock, hang guard, reporting
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            close_out;
        end
    end

    task close_out;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task chk(input [31:0] seen, input [31:0] want);
        tests_run = tests_run + 1;
        if (seen !== want) begin
            n_mismatch = n_mismatch + 1;
            $display("CHECK FAILED t=%0t saw %h want %h", $time, seen, want);
        end
    endtask

    // ==========================================================
    // single bus transfer; read data lands in rd
    task ahb(input w, input [7:0] a, input [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= `HTRANS_NONSEQ;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= w ? d : ~d;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        rd = hrdata;
    endtask

    // busy flags settle a few cycles after the last beat
    task stat_chk;
        repeat (4) @(posedge core_clk);
        ahb(1'b0, `REG_STATUS, 32'h0);
        chk(rd, 32'h0004_0000 | {vld, 8'h00} | {rp, 4'h0} | wp);
    endtask

    task fifo_wr(input [7:0] s);
        integer k;
        ctl.wr_burst(s, WL);
        for (k = 0; k < 16; k++)
            exp_mem[wp][k] = ctl.pat(s, k[3:0]);
        vld[wp] = 1'b1;
        wp = (wp == 3'h4) ? 3'h0 : wp + 3'h1;
    endtask

    // reads spaced exactly one burst apart must stream with no gap
    task read_n(input integer n);
        integer r, e, ent;
        reg [17:0] w;
        fork
            for (r = 0; r < n; r++) begin
                ctl.mpc({1'b1, `MPC_FN_RD_FIFO});
                repeat (14) @(posedge core_clk);
            end
            begin
                repeat (RL + 4) @(posedge core_clk);
                for (e = 0; e < n * 16; e++) begin
                    #1;
                    ent = (rp + e / 16) % 5;
                    w = vld[ent] ? exp_mem[ent][e % 16] : 18'h0;
                    chk(dq_oe_n, 1'b0);
                    chk(dq_out, w[15:0]);
                    chk(mi_oe_n, lane_en == 3'h0);
                    if (lane_en != 3'h0)
                        chk(mi_out, w[17:16]);
                    @(posedge core_clk);
                end
            end
        join
        rp = (rp + n) % 5;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        ahb(1'b0, `REG_CTRL, 32'h0);
        chk(rd, `CTRL_RESET);
        ahb(1'b1, `REG_CTRL, 32'hffff_ffff);
        ahb(1'b0, `REG_CTRL, 32'h0);
        chk(rd, 32'h0007_1f1f);
        ahb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        ahb(1'b1, `REG_STATUS, 32'hffff_ffff);
        lane_en = 3'b101;
        ahb(1'b1, `REG_CTRL, {13'h0, lane_en, 3'h0, RL, 3'h0, WL});
        stat_chk;
        // three entries only, then a full lap: two come back as filler
        for (i = 0; i < 3; i++)
            fifo_wr(8'h10 + i);
        ctl.cmd(`CMD_MODE_REG_WRITE);
        stat_chk;
        read_n(5);
        ctl.mpc(7'h01);
        // one idle cycle so the command bus is not driven twice at once
        @(posedge core_clk);
        ctl.mpc({1'b1, 6'h2a});
        stat_chk;
        // write pointer wraps; two laps of reads leave data intact
        fifo_wr(8'h20);
        fifo_wr(8'h21);
        stat_chk;
        read_n(10);
        // ordinary reads only once training is over
        ctl.cmd(`CMD_READ);
        {wp, rp, vld} = {3'h1, 3'h1, 5'h0};
        stat_chk;
        ctl.cmd(`CMD_READ_AUTO_PRE);
        {wp, rp} = {3'h2, 3'h2};
        stat_chk;
        // each disturbing event wipes the stored patterns
        for (j = 0; j < 5; j++) begin
            fifo_wr(8'h30 + j);
            case (j)
                0: ctl.cmd(`CMD_WRITE);
                1: ctl.cmd(`CMD_MASKED_WRITE);
                2: ctl.cmd(`CMD_MODE_REG_READ);
                3: ctl.mpc({1'b1, `MPC_FN_RD_CAL});
                default: begin
                    cke_pin <= 1'b0;
                    repeat (6) @(posedge core_clk);
                    cke_pin <= 1'b1;
                    repeat (6) @(posedge core_clk);
                end
            endcase
            vld = 5'h0;
            stat_chk;
        end
        // power-down entries clear only the write pointer
        for (j = 0; j < 2; j++) begin
            fifo_wr(8'h40 + j);
            pd_entry <= (j == 0);
            sref_pd_entry <= (j == 1);
            @(posedge core_clk);
            pd_entry <= 1'b0;
            sref_pd_entry <= 1'b0;
            wp = 3'h0;
            stat_chk;
            // wake-up gap before the next fifo write
            repeat (8) @(posedge core_clk);
        end
        // lanes off: mask pins must stay released during a read
        lane_en = 3'h0;
        ahb(1'b1, `REG_CTRL, {16'h0, 3'h0, RL, 3'h0, WL});
        read_n(2);
        close_out;
    end
endmodule // dq_training_fifo_bench
